/* core/sax_pkg.sv */
// Shared constants, types and register map of the segment address extension block.
package sax_pkg;
  localparam int SEG_W = 6;
  localparam int VADDR_W = 16;
  localparam int PADDR_W = 22;
  localparam int AXI_ADDR_W = 10;
  localparam int DEPTH_W = 4;
  localparam int NUM_EXT = 8;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0] REG_PORT0_IDX = 8'hE0;
  localparam logic [7:0] REG_PAGE0_IDX = 8'hF0;
  localparam logic [7:0] REG_CSEG_IDX = 8'hF4;
  localparam logic [7:0] REG_XMODE_IDX = 8'hF6;
  localparam logic [7:0] REG_ISEG_IDX = 8'hF8;
  localparam logic [7:0] REG_DSEG_IDX = 8'hF9;
  localparam logic [7:0] REG_EDGE_IDX = 8'hFA;
  localparam logic [7:0] REG_TOPSEL_IDX = 8'hFB;

  localparam int XMODE_RELOC_BIT = 5;
  localparam int XMODE_STACK_BIT = 6;
  localparam int TOPSEL_NMI_BIT = 0;

  localparam logic [SEG_W-1:0] CSEG_RESET = 6'h00;
  localparam logic [SEG_W-1:0] SEG_RESET = 6'h00;
  localparam logic [SEG_W-1:0] SEG_ZERO = 6'h00;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam logic [7:0] EDGE_RESET = 8'h00;

  localparam logic [VADDR_W-1:0] VEC_RESET = 16'h0000;
  localparam logic [VADDR_W-1:0] VEC_DIVZ = 16'h0002;
  localparam logic [VADDR_W-1:0] VEC_TOP = 16'h0004;
  localparam logic [7:0] VEC_TABLE_PAGE = 8'h00;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    KIND_CODE = 3'h0,
    KIND_DATA = 3'h1,
    KIND_DMA = 3'h2,
    KIND_VEC = 3'h3,
    KIND_TOP = 3'h4,
    KIND_RESET = 3'h5,
    KIND_DIVZ = 3'h6
  } sax_kind_t;

  typedef struct packed {
    sax_kind_t kind;
    logic [VADDR_W-1:0] vaddr;
    logic vec_byte;
  } sax_acc_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_PUSH_PCL = 4'h1,
    ST_PUSH_PCH = 4'h3,
    ST_PUSH_CS = 4'h2,
    ST_PUSH_FL = 4'h6,
    ST_POP_FL = 4'h7,
    ST_POP_CS = 4'h5,
    ST_POP_PCH = 4'h4,
    ST_POP_PCL = 4'hC
  } sax_stk_t;
endpackage

/* core/sax_core.sv */
// Segment address extension: segment select, vectors, interrupt stacking, AXI4-Lite registers.
//
// The AXI4-Lite slave port is this design's own decision.
module sax_core import sax_pkg::*; #(
  parameter int VEC_LOW_W = 2
) (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [AXI_ADDR_W-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  output logic [1:0] o_s_axi_bresp,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  input wire logic [AXI_ADDR_W-1:0] i_s_axi_araddr,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  input wire logic i_acc_valid,
  input wire sax_acc_t i_acc,
  input wire logic i_dma_segment_pick,
  input wire logic [7:0] i_vector_base,
  input wire logic [VEC_LOW_W-1:0] i_vector_chan,
  output logic o_paddr_valid,
  output logic [PADDR_W-1:0] o_paddr,
  input wire logic i_int_enter,
  input wire logic i_trap_enter,
  input wire logic i_int_return,
  input wire logic i_far_load,
  input wire logic [SEG_W-1:0] i_far_seg,
  input wire logic [VADDR_W-1:0] i_pc,
  input wire logic [7:0] i_flags,
  input wire logic [7:0] i_pop_data,
  output logic o_stack_push,
  output logic o_stack_pop,
  output logic [7:0] o_stack_data,
  output logic o_busy,
  input wire logic [NUM_EXT-1:0] i_ext_int,
  input wire logic i_nmi,
  input wire logic i_wdt_irq,
  output logic [NUM_EXT-1:0] o_ext_req,
  output logic o_top_req,
  output logic o_ports_relocated
);
  ////////////////////////////////////////////////////////////////////////////
  logic [SEG_W-1:0] cseg_ff, iseg_ff, dseg_ff;
  logic [7:0] page_ff [4];
  logic reloc_ff, stack_en_ff, top_nmi_ff, trap_ff;
  logic [NUM_EXT-1:0] edge_sel_ff;
  logic [DEPTH_W-1:0] depth_ff;
  logic [VADDR_W-1:0] pc_ff;
  logic [7:0] flags_ff;
  sax_stk_t state_ff, nxt_state;
  logic awready_ff, arready_ff, bvalid_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [7:0] rdata_ff;

  // Bus slave: a write is taken once address and data are both offered.
  wire nxt_awready = i_s_axi_awvalid & i_s_axi_wvalid & ~awready_ff & ~bvalid_ff;
  wire nxt_arready = i_s_axi_arvalid & ~arready_ff & ~rvalid_ff;
  wire wr_go = awready_ff & i_s_axi_awvalid & i_s_axi_wvalid;
  wire rd_go = arready_ff & i_s_axi_arvalid;
  wire [7:0] aw_idx = i_s_axi_awaddr[9:2];
  wire [7:0] ar_idx = i_s_axi_araddr[9:2];
  wire [7:0] page_base = reloc_ff ? REG_PORT0_IDX : REG_PAGE0_IDX;
  wire aw_page = aw_idx[7:2] == page_base[7:2];
  wire ar_page = ar_idx[7:2] == page_base[7:2];
  wire aw_known = aw_page | (aw_idx inside {REG_CSEG_IDX, REG_XMODE_IDX, REG_ISEG_IDX,
                                            REG_DSEG_IDX, REG_EDGE_IDX, REG_TOPSEL_IDX});
  wire ar_known = ar_page | (ar_idx inside {REG_CSEG_IDX, REG_XMODE_IDX, REG_ISEG_IDX,
                                            REG_DSEG_IDX, REG_EDGE_IDX, REG_TOPSEL_IDX});
  wire wr_en = wr_go & i_s_axi_wstrb[0];
  wire [7:0] wbyte = i_s_axi_wdata[7:0];
  wire cs_wr = wr_en & (aw_idx == REG_CSEG_IDX);
  wire [7:0] xmode_rd = 8'(({7'h00, stack_en_ff} << XMODE_STACK_BIT)
                         | ({7'h00, reloc_ff} << XMODE_RELOC_BIT));
  wire [7:0] rd_byte =
    ar_page ? page_ff[ar_idx[1:0]] :
    (ar_idx == REG_CSEG_IDX) ? {2'h0, cseg_ff} :
    (ar_idx == REG_XMODE_IDX) ? xmode_rd :
    (ar_idx == REG_ISEG_IDX) ? {2'h0, iseg_ff} :
    (ar_idx == REG_DSEG_IDX) ? {2'h0, dseg_ff} :
    (ar_idx == REG_EDGE_IDX) ? edge_sel_ff :
    (ar_idx == REG_TOPSEL_IDX) ? {7'h00, top_nmi_ff} : 8'h00;

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      awready_ff <= 1'b0;
      arready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= 8'h00;
    end else begin
      awready_ff <= nxt_awready;
      arready_ff <= nxt_arready;
      if (wr_go) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= aw_known ? RESP_OKAY : RESP_SLVERR;
      end else if (i_s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
      if (rd_go) begin
        rvalid_ff <= 1'b1;
        rresp_ff <= ar_known ? RESP_OKAY : RESP_SLVERR;
        rdata_ff <= rd_byte;
      end else if (i_s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Only six segment bits are stored, so reserved top bits always read zero.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      iseg_ff <= SEG_RESET;
      dseg_ff <= SEG_RESET;
      reloc_ff <= 1'b0;
      stack_en_ff <= 1'b0;
      edge_sel_ff <= EDGE_RESET;
      top_nmi_ff <= 1'b0;
    end else if (wr_en) begin
      if (aw_idx == REG_ISEG_IDX) iseg_ff <= wbyte[SEG_W-1:0];
      if (aw_idx == REG_DSEG_IDX) dseg_ff <= wbyte[SEG_W-1:0];
      if (aw_idx == REG_XMODE_IDX) begin
        reloc_ff <= wbyte[XMODE_RELOC_BIT];
        stack_en_ff <= wbyte[XMODE_STACK_BIT];
      end
      if (aw_idx == REG_EDGE_IDX) edge_sel_ff <= wbyte;
      if (aw_idx == REG_TOPSEL_IDX) top_nmi_ff <= wbyte[TOPSEL_NMI_BIT];
    end
  end

  for (genvar g = 0; g < 4; g++) begin : g_page
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        page_ff[g] <= PAGE_RESET;
      end else if (wr_en && aw_page && aw_idx[1:0] == 2'(g)) begin
        page_ff[g] <= wbyte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stacking sequencer. Events arriving while busy are ignored by design.
  wire idle = state_ff == ST_IDLE;
  wire start_int = idle & i_int_enter;
  wire start_trap = idle & i_trap_enter & ~i_int_enter;
  wire in_service = depth_ff != '0;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (i_int_enter || i_trap_enter) nxt_state = ST_PUSH_PCL;
        else if (i_int_return && in_service) nxt_state = ST_POP_FL;
      end
      ST_PUSH_PCL: nxt_state = ST_PUSH_PCH;
      ST_PUSH_PCH: begin
        if (trap_ff) nxt_state = ST_IDLE;
        else if (stack_en_ff) nxt_state = ST_PUSH_CS;
        else nxt_state = ST_PUSH_FL;
      end
      ST_PUSH_CS: nxt_state = ST_PUSH_FL;
      ST_PUSH_FL: nxt_state = ST_IDLE;
      ST_POP_FL: nxt_state = stack_en_ff ? ST_POP_CS : ST_POP_PCH;
      ST_POP_CS: nxt_state = ST_POP_PCH;
      ST_POP_PCH: nxt_state = ST_POP_PCL;
      ST_POP_PCL: nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  wire [VADDR_W-1:0] pc_src = idle ? i_pc : pc_ff;
  wire nxt_push = nxt_state inside {ST_PUSH_PCL, ST_PUSH_PCH, ST_PUSH_CS, ST_PUSH_FL};
  wire nxt_pop = nxt_state inside {ST_POP_FL, ST_POP_CS, ST_POP_PCH, ST_POP_PCL};
  wire [7:0] nxt_data =
    (nxt_state == ST_PUSH_PCL) ? pc_src[7:0] :
    (nxt_state == ST_PUSH_PCH) ? pc_src[15:8] :
    (nxt_state == ST_PUSH_CS) ? {2'h0, cseg_ff} :
    (nxt_state == ST_PUSH_FL) ? flags_ff : 8'h00;

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_ff <= ST_IDLE;
      trap_ff <= 1'b0;
      pc_ff <= '0;
      flags_ff <= 8'h00;
      depth_ff <= '0;
      o_stack_push <= 1'b0;
      o_stack_pop <= 1'b0;
      o_stack_data <= 8'h00;
      o_busy <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      o_stack_push <= nxt_push;
      o_stack_pop <= nxt_pop;
      o_stack_data <= nxt_data;
      o_busy <= nxt_state != ST_IDLE;
      if (start_int || start_trap) begin
        trap_ff <= start_trap;
        pc_ff <= i_pc;
        flags_ff <= i_flags;
      end
      if (start_int) depth_ff <= depth_ff + 1'b1;
      else if (state_ff == ST_POP_PCL) depth_ff <= depth_ff - 1'b1;
    end
  end

  // A popped segment wins over a far transfer, which wins over a software write.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cseg_ff <= CSEG_RESET;
    end else if (state_ff == ST_POP_CS) begin
      cseg_ff <= i_pop_data[SEG_W-1:0];
    end else if (state_ff == ST_PUSH_FL && stack_en_ff) begin
      cseg_ff <= iseg_ff;
    end else if (i_far_load) begin
      cseg_ff <= i_far_seg;
    end else if (cs_wr) begin
      cseg_ff <= wbyte[SEG_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Physical address formation.
  wire is_dma = i_acc.kind == KIND_DMA;
  wire use_dseg = is_dma & i_dma_segment_pick;
  wire use_iseg = is_dma | (i_acc.kind == KIND_CODE & in_service & ~stack_en_ff);
  wire [SEG_W-1:0] seg_sel = use_dseg ? dseg_ff : use_iseg ? iseg_ff : cseg_ff;
  wire [7:0] vec_num = {i_vector_base[7:VEC_LOW_W+1], i_vector_chan, i_acc.vec_byte};
  wire [7:0] page_num = page_ff[i_acc.vaddr[15:14]];
  wire [PADDR_W-1:0] nxt_paddr =
    (i_acc.kind == KIND_RESET) ? {SEG_ZERO, VEC_RESET[15:1], i_acc.vec_byte} :
    (i_acc.kind == KIND_DIVZ) ? {cseg_ff, VEC_DIVZ[15:1], i_acc.vec_byte} :
    (i_acc.kind == KIND_TOP) ? {iseg_ff, VEC_TOP[15:1], i_acc.vec_byte} :
    (i_acc.kind == KIND_VEC) ? {iseg_ff, VEC_TABLE_PAGE, vec_num} :
    (i_acc.kind == KIND_DATA) ? {page_num, i_acc.vaddr[13:0]} :
    {seg_sel, i_acc.vaddr};

  // Top-level channel: external pin or watchdog, both as rising edges.
  logic [NUM_EXT-1:0] ext_s1_ff, ext_s2_ff, ext_prev_ff;
  logic nmi_s1_ff, nmi_s2_ff, nmi_prev_ff, wdt_prev_ff;
  wire [NUM_EXT-1:0] nxt_ext_req = (ext_s2_ff & ~ext_prev_ff & edge_sel_ff)
                                 | (~ext_s2_ff & ext_prev_ff & ~edge_sel_ff);
  wire nxt_top_req = top_nmi_ff ? (nmi_s2_ff & ~nmi_prev_ff) : (i_wdt_irq & ~wdt_prev_ff);

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_paddr_valid <= 1'b0;
      o_paddr <= '0;
      ext_s1_ff <= '0;
      ext_s2_ff <= '0;
      ext_prev_ff <= '0;
      nmi_s1_ff <= 1'b0;
      nmi_s2_ff <= 1'b0;
      nmi_prev_ff <= 1'b0;
      wdt_prev_ff <= 1'b0;
      o_ext_req <= '0;
      o_top_req <= 1'b0;
      o_ports_relocated <= 1'b0;
    end else begin
      o_paddr_valid <= i_acc_valid;
      if (i_acc_valid) o_paddr <= nxt_paddr;
      ext_s1_ff <= i_ext_int;
      ext_s2_ff <= ext_s1_ff;
      ext_prev_ff <= ext_s2_ff;
      nmi_s1_ff <= i_nmi;
      nmi_s2_ff <= nmi_s1_ff;
      nmi_prev_ff <= nmi_s2_ff;
      wdt_prev_ff <= i_wdt_irq;
      o_ext_req <= nxt_ext_req;
      o_top_req <= nxt_top_req;
      o_ports_relocated <= reloc_ff;
    end
  end

  assign o_s_axi_awready = awready_ff;
  assign o_s_axi_wready = awready_ff;
  assign o_s_axi_bvalid = bvalid_ff;
  assign o_s_axi_bresp = bresp_ff;
  assign o_s_axi_arready = arready_ff;
  assign o_s_axi_rvalid = rvalid_ff;
  assign o_s_axi_rresp = rresp_ff;
  assign o_s_axi_rdata = {24'h000000, rdata_ff};

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  AST_VEC_SEG: assert property (i_acc_valid && i_acc.kind == KIND_VEC |=>
    o_paddr_valid && o_paddr[21:16] == $past(iseg_ff) && o_paddr[15:8] == VEC_TABLE_PAGE)
    else $error("Vector fetch left the interrupt segment table.");
  AST_DMA_ISEG: assert property (i_acc_valid && is_dma && !i_dma_segment_pick |=>
    o_paddr[21:16] == $past(iseg_ff)) else $error("DMA without pick missed interrupt segment.");
  AST_DMA_DSEG: assert property (i_acc_valid && is_dma && i_dma_segment_pick |=>
    o_paddr[21:16] == $past(dseg_ff)) else $error("DMA with pick missed DMA segment.");
  AST_RESET_VEC: assert property (i_acc_valid && i_acc.kind == KIND_RESET |=>
    o_paddr[21:1] == '0) else $error("Reset vector not at physical zero.");
  AST_TOP_VEC: assert property (i_acc_valid && i_acc.kind == KIND_TOP |=>
    o_paddr[15:1] == VEC_TOP[15:1] && o_paddr[21:16] == $past(iseg_ff))
    else $error("Top-level vector misplaced.");
  AST_DIVZ_VEC: assert property (i_acc_valid && i_acc.kind == KIND_DIVZ |=>
    o_paddr[15:1] == VEC_DIVZ[15:1] && o_paddr[21:16] == $past(cseg_ff))
    else $error("Divide-by-zero vector misplaced.");
  AST_TRAP_FRAME: assert property (start_trap |=> o_stack_push [*2] ##1 !o_stack_push)
    else $error("Trap frame is not two bytes.");
  AST_COMPAT_FRAME: assert property (start_int && !stack_en_ff |=>
    o_stack_push [*3] ##1 !o_stack_push) else $error("Compatible frame is not three bytes.");
  AST_STACKED_LOAD: assert property (start_int && stack_en_ff && !i_far_load |=>
    o_stack_push [*4] ##1 cseg_ff == iseg_ff) else $error("Code segment not loaded.");
  AST_PUSH_ORDER: assert property (start_int |=> o_stack_data == $past(i_pc[7:0])
    ##1 o_stack_data == $past(i_pc[15:8], 2)) else $error("PC bytes pushed out of order.");
  AST_ISR_CODE: assert property (i_acc_valid && i_acc.kind == KIND_CODE && in_service
    && !stack_en_ff |=> o_paddr[21:16] == $past(iseg_ff))
    else $error("Service code not fetched from interrupt segment.");
  AST_DATA_PAGE: assert property (i_acc_valid && i_acc.kind == KIND_DATA |=>
    o_paddr[13:0] == $past(i_acc.vaddr[13:0])) else $error("Page offset corrupted.");
  AST_CODE_ADDR: assert property (i_acc_valid && i_acc.kind == KIND_CODE && !in_service
    |=> o_paddr == {$past(cseg_ff), $past(i_acc.vaddr)}) else $error("Code address wrong.");
  AST_CSEG_SRC: assert property ($changed(cseg_ff) |-> $past(i_far_load) || $past(cs_wr)
    || $past(state_ff) inside {ST_POP_CS, ST_PUSH_FL}) else $error("Code segment changed alone.");

  COV_STACKED: cover property (start_int && stack_en_ff);
  COV_RETURN: cover property (state_ff == ST_POP_CS ##3 idle);
  COV_DMA_PICK: cover property (i_acc_valid && use_dseg);
  COV_TRAP: cover property (start_trap);
endmodule

/* sim/sax_stack_model.sv */
// Behavioural system stack standing on the far side of the stacking sequencer.
module sax_stack_model (
  input wire logic i_ref_clk,
  input wire logic i_push,
  input wire logic i_pop,
  input wire logic [7:0] i_data,
  output logic [7:0] o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem[$];
  logic [7:0] top_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Bytes leave in reverse order, so a misordered frame restores the wrong segment.
  always @(posedge i_ref_clk) begin
    if (i_push === 1'b1) mem.push_back(i_data);
    if (i_pop === 1'b1 && mem.size() > 0) void'(mem.pop_back());
    top_ff <= (mem.size() > 0) ? mem[$] : 8'h00;
  end
  // Outside a pop the bus shows the inverse, so a mistimed sample cannot pass by luck.
  assign o_data = (i_pop === 1'b1) ? top_ff : ~top_ff;
endmodule

/* sim/segment_address_extension_tb_top.sv */
// Self-checking testbench of the segment address extension block.
module segment_address_extension_tb_top import sax_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_ref_clk, i_resetn, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid;
  logic i_s_axi_rready, i_acc_valid, i_dma_segment_pick, i_int_enter, i_trap_enter;
  logic i_int_return, i_far_load, i_nmi, i_wdt_irq, o_s_axi_awready, o_s_axi_wready;
  logic o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid, o_paddr_valid, o_stack_push;
  logic o_stack_pop, o_busy, o_top_req, o_ports_relocated, svc, stk;
  logic [AXI_ADDR_W-1:0] i_s_axi_awaddr, i_s_axi_araddr;
  logic [31:0] i_s_axi_wdata, o_s_axi_rdata;
  logic [3:0] i_s_axi_wstrb;
  logic [1:0] o_s_axi_bresp, o_s_axi_rresp, i_vector_chan, vc;
  sax_acc_t i_acc;
  logic [7:0] i_vector_base, i_flags, i_pop_data, o_stack_data, vb;
  logic [7:0] dp[4];
  logic [SEG_W-1:0] i_far_seg, cseg, iseg, dseg, cs_old;
  logic [VADDR_W-1:0] i_pc;
  logic [PADDR_W-1:0] o_paddr;
  logic [NUM_EXT-1:0] i_ext_int, o_ext_req;
  int err_count, samples_checked, ext_cnt, top_cnt;
  logic [63:0] exp_pa[$], exp_push[$], exp_rd[$], exp_br[$];

  sax_core u_sax_core (.i_ref_clk, .i_resetn, .i_s_axi_awvalid, .o_s_axi_awready,
    .i_s_axi_awaddr, .i_s_axi_wvalid, .o_s_axi_wready, .i_s_axi_wdata, .i_s_axi_wstrb,
    .o_s_axi_bvalid, .i_s_axi_bready, .o_s_axi_bresp, .i_s_axi_arvalid, .o_s_axi_arready,
    .i_s_axi_araddr, .o_s_axi_rvalid, .i_s_axi_rready, .o_s_axi_rdata, .o_s_axi_rresp,
    .i_acc_valid, .i_acc, .i_dma_segment_pick, .i_vector_base, .i_vector_chan, .o_paddr_valid,
    .o_paddr, .i_int_enter, .i_trap_enter, .i_int_return, .i_far_load, .i_far_seg, .i_pc,
    .i_flags, .i_pop_data, .o_stack_push, .o_stack_pop, .o_stack_data, .o_busy, .i_ext_int,
    .i_nmi, .i_wdt_irq, .o_ext_req, .o_top_req, .o_ports_relocated);
  sax_stack_model u_sax_stack_model (.i_ref_clk, .i_push(o_stack_push), .i_pop(o_stack_pop),
    .i_data(o_stack_data), .o_data(i_pop_data));

  initial begin
    i_ref_clk = 1'b0;
    forever #10 i_ref_clk = ~i_ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  function automatic logic [PADDR_W-1:0] pa(sax_kind_t k, logic [15:0] v, logic b, logic pk);
    case (k)
      KIND_RESET: return {6'h00, 15'h0000, b};
      KIND_DIVZ: return {cseg, 15'h0001, b};
      KIND_TOP: return {iseg, 15'h0002, b};
      KIND_VEC: return {iseg, 8'h00, vb[7:3], vc, b};
      KIND_DATA: return {dp[v[15:14]], v[13:0]};
      KIND_DMA: return {pk ? dseg : iseg, v};
      default: return {(svc && !stk) ? iseg : cseg, v};
    endcase
  endfunction

  // Results are compared in the cycle they appear, oldest note first.
  always @(posedge i_ref_clk) begin
    if (i_resetn === 1'b1) begin
      if (o_paddr_valid === 1'b1) chk("paddr", 64'(o_paddr), exp_pa.pop_front());
      if (o_stack_push === 1'b1) chk("push", 64'(o_stack_data), exp_push.pop_front());
      if (o_s_axi_rvalid === 1'b1 && i_s_axi_rready === 1'b1)
        chk("rdata", 64'({o_s_axi_rresp, o_s_axi_rdata}), exp_rd.pop_front());
      if (o_s_axi_bvalid === 1'b1 && i_s_axi_bready === 1'b1)
        chk("bresp", 64'(o_s_axi_bresp), exp_br.pop_front());
      ext_cnt += $countones(o_ext_req);
      top_cnt += int'(o_top_req === 1'b1);
    end
  end

  // Waits are open ended; only the watchdog may end a hung handshake.
  task automatic wr(logic [7:0] idx, logic [7:0] d, logic [1:0] r);
    exp_br.push_back(64'(r));
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wvalid <= 1'b1;
    i_s_axi_awaddr <= {idx, 2'b00};
    i_s_axi_wdata <= {24'h000000, d};
    i_s_axi_bready <= 1'b1;
    do @(posedge i_ref_clk); while (o_s_axi_awready !== 1'b1);
    i_s_axi_awvalid <= 1'b0;
    i_s_axi_wvalid <= 1'b0;
    do @(posedge i_ref_clk); while (o_s_axi_bvalid !== 1'b1);
    i_s_axi_bready <= 1'b0;
    @(posedge i_ref_clk);
  endtask

  task automatic rd(logic [7:0] idx, logic [33:0] e);
    exp_rd.push_back(64'(e));
    i_s_axi_arvalid <= 1'b1;
    i_s_axi_araddr <= {idx, 2'b00};
    i_s_axi_rready <= 1'b1;
    do @(posedge i_ref_clk); while (o_s_axi_arready !== 1'b1);
    i_s_axi_arvalid <= 1'b0;
    do @(posedge i_ref_clk); while (o_s_axi_rvalid !== 1'b1);
    i_s_axi_rready <= 1'b0;
    @(posedge i_ref_clk);
  endtask

  task automatic acc(sax_kind_t k, logic [15:0] v, logic b, logic pk, logic hold);
    vb = 8'($urandom);
    vc = 2'($urandom);
    exp_pa.push_back(64'(pa(k, v, b, pk)));
    i_acc_valid <= 1'b1;
    i_acc <= '{k, v, b};
    i_dma_segment_pick <= pk;
    i_vector_base <= vb; // Base bits come from software, channel bits from hardware.
    i_vector_chan <= vc;
    @(posedge i_ref_clk);
    if (!hold) begin
      i_acc_valid <= 1'b0;
      @(posedge i_ref_clk);
    end
  endtask

  // Every access kind back to back, DMA once with each pick value.
  task automatic sweep();
    for (int i = 0; i < 14; i++) begin
      acc(sax_kind_t'(3'(i % 7)), 16'($urandom), 1'($urandom), i >= 7, i < 13);
    end
  endtask

  task automatic ent(logic trap);
    logic [15:0] pc;
    logic [7:0] fl;
    pc = 16'($urandom);
    fl = 8'($urandom);
    cs_old = cseg;
    exp_push.push_back(64'(pc[7:0]));
    exp_push.push_back(64'(pc[15:8]));
    if (!trap && stk) exp_push.push_back(64'({2'b00, cseg}));
    if (!trap) exp_push.push_back(64'(fl));
    i_pc <= pc;
    i_flags <= fl;
    i_int_enter <= !trap;
    i_trap_enter <= trap;
    @(posedge i_ref_clk);
    i_int_enter <= 1'b0;
    i_trap_enter <= 1'b0;
    do @(posedge i_ref_clk); while (o_busy !== 1'b0);
    svc = svc | !trap;
    if (!trap && stk) cseg = iseg;
  endtask

  task automatic ret();
    i_int_return <= 1'b1;
    @(posedge i_ref_clk);
    i_int_return <= 1'b0;
    do @(posedge i_ref_clk); while (o_busy !== 1'b0);
    svc = 1'b0;
    if (stk) cseg = cs_old;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid, i_s_axi_rready} = '0;
    {i_acc_valid, i_dma_segment_pick, i_int_enter, i_trap_enter, i_int_return} = '0;
    {i_far_load, i_nmi, i_wdt_irq, svc, stk, i_ext_int, i_far_seg, i_pc, i_flags} = '0;
    {i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wdata, i_acc, i_vector_base, i_vector_chan} = '0;
    i_s_axi_wstrb = 4'hF;
    cseg = 6'h00;
    i_resetn = 1'b0;
    void'($urandom(32'h3ACA));
    repeat (2) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    acc(KIND_CODE, 16'($urandom), 1'b0, 1'b0, 1'b1);
    acc(KIND_RESET, 16'($urandom), 1'b1, 1'b0, 1'b0);
    rd(REG_CSEG_IDX, 34'h000000000);
    iseg = 6'($urandom);
    dseg = 6'($urandom);
    wr(REG_ISEG_IDX, {2'b00, iseg}, RESP_OKAY); // Top bits kept clear, loaded first.
    wr(REG_DSEG_IDX, {2'b00, dseg}, RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      dp[i] = 8'($urandom);
      wr(REG_PAGE0_IDX + 8'(i), dp[i], RESP_OKAY);
    end
    rd(REG_ISEG_IDX, {2'h0, 26'h0000000, iseg});
    rd(REG_DSEG_IDX, {2'h0, 26'h0000000, dseg});
    wr(8'h10, 8'hFF, RESP_SLVERR);
    rd(8'h10, {RESP_SLVERR, 32'h00000000});
    sweep();
    // The code segment is moved here by a far transfer, not by a software write.
    cseg = 6'($urandom);
    i_far_load <= 1'b1;
    i_far_seg <= cseg;
    @(posedge i_ref_clk);
    i_far_load <= 1'b0;
    @(posedge i_ref_clk);
    sweep();
    ent(1'b0);
    sweep();
    ret();
    sweep();
    wr(REG_XMODE_IDX, 8'h40, RESP_OKAY);
    stk = 1'b1;
    ent(1'b0);
    rd(REG_CSEG_IDX, {2'h0, 26'h0000000, iseg});
    sweep();
    ret();
    sweep();
    ent(1'b1);
    sweep();
    wr(REG_XMODE_IDX, 8'h20, RESP_OKAY);
    stk = 1'b0;
    chk("relocated", 64'(o_ports_relocated), 64'h1);
    rd(REG_PAGE0_IDX, {RESP_SLVERR, 32'h00000000});
    rd(REG_PORT0_IDX, {2'h0, 24'h000000, dp[0]});
    wr(REG_EDGE_IDX, 8'h01, RESP_OKAY);
    // Channel 0 fires on its rise only, channel 1 keeps the falling default.
    i_ext_int <= 8'h03;
    repeat (8) @(posedge i_ref_clk);
    i_ext_int <= 8'h00;
    repeat (8) @(posedge i_ref_clk);
    i_wdt_irq <= 1'b1;
    repeat (6) @(posedge i_ref_clk);
    chk("ext_req", 64'(ext_cnt), 64'h2);
    chk("top_req", 64'(top_cnt), 64'h1);
    wr(REG_TOPSEL_IDX, 8'h01, RESP_OKAY);
    i_nmi <= 1'b1;
    repeat (6) @(posedge i_ref_clk);
    chk("nmi_req", 64'(top_cnt), 64'h2);
    end_sim();
  end

  // The whole sequence needs well under a thousand cycles.
  initial begin
    #400000;
    err_count++;
    end_sim();
  end
endmodule
